// ==== timer_compare_core_map.vh ====
`ifndef TIMER_COMPARE_CORE_MAP_VH
`define TIMER_COMPARE_CORE_MAP_VH

// Register byte offsets
`define OFS_T0_CTRL     8'h00
`define OFS_T0_COUNT    8'h04
`define OFS_T0_CMP_A    8'h08
`define OFS_T0_CMP_B    8'h0c
`define OFS_C16_HIGH    8'h10
`define OFS_C16_LOW     8'h14
`define OFS_T1_CTRL     8'h18
`define OFS_T1_COUNT    8'h1c
`define OFS_IRQ_STATUS  8'h20
`define OFS_IRQ_CLEAR   8'h24
`define OFS_IRQ_ENABLE  8'h28

// Field positions
`define CLK_SEL_LSB     0
`define CLK_SEL_MSB     2
`define T1_MODE_LSB     0
`define T1_MODE_MSB     3
`define T1_SEL_LSB      4
`define T1_SEL_MSB      6
`define ST_MATCH_A      0
`define ST_MATCH_B      1
`define ST_OVF0         2
`define ST_MATCH16      3
`define ST_WIDTH        4

// Clock select codes
`define SEL_STOP        3'h0
`define SEL_DIV1        3'h1
`define SEL_DIV8        3'h2
`define SEL_DIV64       3'h3
`define SEL_DIV256      3'h4
`define SEL_DIV1024     3'h5
`define SEL_EXT_FALL    3'h6
`define SEL_EXT_RISE    3'h7

// Timer1 waveform modes of note
`define MODE_NORMAL     4'h0
`define MODE_CTC_CMP    4'h4
`define MODE_CTC_CAP    4'hc

// Fixed TOP values, reset values and response codes
`define TOP_8BIT        16'h00ff
`define TOP_9BIT        16'h01ff
`define TOP_10BIT       16'h03ff
`define TOP_MAX         16'hffff
`define RST_BYTE        8'h00
`define RST_WORD        16'h0000
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// ==== timer_compare_core.v ====
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "timer_compare_core_map.vh"

// How it works
// - Select zero stops; codes one to five prescaled I/O clock
// - Codes six, seven count external pin edges on Timer0; Timer1 stops
// - Pin edges count even when pin drives
// - Counter register fully readable and writable
// - Timer0 counter write blocks next compare match
// - Both compare bytes checked every timer tick
// - Word compare double buffered in PWM modes
// - Normal and clear-on-match modes write directly
// - Buffer moves to compare at TOP/BOTTOM
// - CPU reaches buffer when buffering is active
// - Compare word changes on direct write or refresh
// - Word reads bypass the high-byte latch
// - High byte written first, only into latch
// - Low write loads both bytes same cycle
module timer_compare_core (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        ext_count_pin,
  output reg         wave_out_a,
  output reg         wave_out_b,
  output reg         wave_out_16,
  output wire        irq
);

  // Write channel holding
  reg        aw_full_reg;
  reg [7:0]  aw_addr_reg;
  reg        w_full_reg;
  reg [31:0] w_data_reg;
  reg        w_lane0_reg;

  // Timer0 state
  reg [2:0]  clk_sel_reg;
  reg [7:0]  counter8_value;
  reg [7:0]  compare8_a;
  reg [7:0]  compare8_b;
  reg        block_match_reg;

  // Timer1 state
  reg [3:0]  t1_mode_reg;
  reg [2:0]  t1_sel_reg;
  reg [15:0] counter16_value;
  reg        count_up_reg;
  reg [15:0] compare16_word;
  reg [15:0] compare16_buf_reg;
  reg [7:0]  high_latch_reg;

  // Shared prescaler, pin sync and interrupt state
  reg [9:0]  pre_reg;
  reg        pin_sync1_reg;
  reg        pin_sync2_reg;
  reg        pin_prev_reg;
  reg [`ST_WIDTH-1:0] status_reg;
  reg [`ST_WIDTH-1:0] enable_reg;

  wire do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire wr_en    = do_write & w_lane0_reg;
  wire [7:0] wbyte = w_data_reg[7:0];

  assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire wr_ctrl0  = wr_en & (aw_addr_reg == `OFS_T0_CTRL);
  wire wr_cnt0   = wr_en & (aw_addr_reg == `OFS_T0_COUNT);
  wire wr_cmpa   = wr_en & (aw_addr_reg == `OFS_T0_CMP_A);
  wire wr_cmpb   = wr_en & (aw_addr_reg == `OFS_T0_CMP_B);
  wire wr_high   = wr_en & (aw_addr_reg == `OFS_C16_HIGH);
  wire wr_low    = wr_en & (aw_addr_reg == `OFS_C16_LOW);
  wire wr_ctrl1  = wr_en & (aw_addr_reg == `OFS_T1_CTRL);
  wire wr_cnt1   = wr_en & (aw_addr_reg == `OFS_T1_COUNT);
  wire wr_clear  = wr_en & (aw_addr_reg == `OFS_IRQ_CLEAR);
  wire wr_enable = wr_en & (aw_addr_reg == `OFS_IRQ_ENABLE);

  // Pin edges, taken from the second sync stage onward
  wire pin_fall = pin_prev_reg & ~pin_sync2_reg;
  wire pin_rise = ~pin_prev_reg & pin_sync2_reg;

  // Prescaler taps, shared by both timers
  function sel_tick;
    input [2:0] sel;
    input [9:0] pre;
    input       fall;
    input       rise;
    begin
      case (sel)
        `SEL_DIV1:     sel_tick = 1'b1;
        `SEL_DIV8:     sel_tick = &pre[2:0];
        `SEL_DIV64:    sel_tick = &pre[5:0];
        `SEL_DIV256:   sel_tick = &pre[7:0];
        `SEL_DIV1024:  sel_tick = &pre[9:0];
        `SEL_EXT_FALL: sel_tick = fall;
        `SEL_EXT_RISE: sel_tick = rise;
        default:       sel_tick = 1'b0;
      endcase
    end
  endfunction

  wire tick0 = sel_tick(clk_sel_reg, pre_reg, pin_fall, pin_rise);
  // Timer1 has no external source here; codes 6 and 7 stop it
  wire tick1 = sel_tick(t1_sel_reg, pre_reg, 1'b0, 1'b0);

  // Timer0 compare
  // suppress after write
  wire match_a = tick0 & ~block_match_reg &
                 (counter8_value == compare8_a);
  wire match_b = tick0 & ~block_match_reg &
                 (counter8_value == compare8_b);
  wire ovf0    = tick0 & (counter8_value == 8'hff);

  // Timer1 mode decode
  wire mode_direct = (t1_mode_reg == `MODE_NORMAL) |
                     (t1_mode_reg == `MODE_CTC_CMP) |
                     (t1_mode_reg == `MODE_CTC_CAP);
  wire dbuf_on = ~mode_direct;
  wire mode_updown = (t1_mode_reg == 4'h1) | (t1_mode_reg == 4'h2) |
                     (t1_mode_reg == 4'h3) | (t1_mode_reg == 4'h8) |
                     (t1_mode_reg == 4'h9) | (t1_mode_reg == 4'ha) |
                     (t1_mode_reg == 4'hb);
  // Phase and frequency correct modes refresh at BOTTOM
  wire upd_at_bottom = ~mode_updown | (t1_mode_reg == 4'h8) |
                       (t1_mode_reg == 4'h9);

  reg [15:0] top16;
  always @* begin
    case (t1_mode_reg)
      4'h1, 4'h5: top16 = `TOP_8BIT;
      4'h2, 4'h6: top16 = `TOP_9BIT;
      4'h3, 4'h7: top16 = `TOP_10BIT;
      `MODE_CTC_CMP: top16 = compare16_word;
      default:    top16 = `TOP_MAX;
    endcase
  end

  wire at_top  = counter16_value == top16;
  wire at_bot  = counter16_value == `RST_WORD;
  wire refresh = tick1 & dbuf_on &
                 (upd_at_bottom ? at_bot : at_top);
  wire match16 = tick1 & (counter16_value == compare16_word);

  wire [`ST_WIDTH-1:0] st_set;
  assign st_set[`ST_MATCH_A] = match_a;
  assign st_set[`ST_MATCH_B] = match_b;
  assign st_set[`ST_OVF0]    = ovf0;
  assign st_set[`ST_MATCH16] = match16;

  assign irq = |(status_reg & enable_reg);

  // AXI write path; address and data may come in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg  <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_full_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_lane0_reg  <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg  <= 1'b1;
        w_data_reg  <= s_axi_wdata;
        w_lane0_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg[1:0] != 2'b00 ||
                        aw_addr_reg > `OFS_IRQ_ENABLE) ? `RESP_SLVERR
                                                       : `RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read path; data registered one cycle after the address
  reg [31:0] rd_mux;
  reg        rd_hit;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == `OFS_T0_CTRL) begin
      rd_mux[`CLK_SEL_MSB:`CLK_SEL_LSB] = clk_sel_reg;
    end else if (s_axi_araddr == `OFS_T0_COUNT) begin
      rd_mux[7:0] = counter8_value;
    end else if (s_axi_araddr == `OFS_T0_CMP_A) begin
      rd_mux[7:0] = compare8_a;
    end else if (s_axi_araddr == `OFS_T0_CMP_B) begin
      rd_mux[7:0] = compare8_b;
    end else if (s_axi_araddr == `OFS_C16_HIGH) begin
      rd_mux[7:0] = dbuf_on ? compare16_buf_reg[15:8]
                            : compare16_word[15:8];
    end else if (s_axi_araddr == `OFS_C16_LOW) begin
      rd_mux[7:0] = dbuf_on ? compare16_buf_reg[7:0]
                            : compare16_word[7:0];
    end else if (s_axi_araddr == `OFS_T1_CTRL) begin
      rd_mux[`T1_MODE_MSB:`T1_MODE_LSB] = t1_mode_reg;
      rd_mux[`T1_SEL_MSB:`T1_SEL_LSB]   = t1_sel_reg;
    end else if (s_axi_araddr == `OFS_T1_COUNT) begin
      rd_mux[15:0] = counter16_value;
    end else if (s_axi_araddr == `OFS_IRQ_STATUS) begin
      rd_mux[`ST_WIDTH-1:0] = status_reg;
    end else if (s_axi_araddr == `OFS_IRQ_CLEAR) begin
      rd_mux = 32'h0000_0000;
    end else if (s_axi_araddr == `OFS_IRQ_ENABLE) begin
      rd_mux[`ST_WIDTH-1:0] = enable_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Prescaler and external pin synchroniser
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg       <= 10'h000;
      pin_sync1_reg <= 1'b0;
      pin_sync2_reg <= 1'b0;
      pin_prev_reg  <= 1'b0;
    end else begin
      pre_reg       <= pre_reg + 10'h001;
      pin_sync1_reg <= ext_count_pin;
      pin_sync2_reg <= pin_sync1_reg;
      pin_prev_reg  <= pin_sync2_reg;
    end
  end

  // Timer0 counter and compare registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      clk_sel_reg     <= `SEL_STOP;
      counter8_value  <= `RST_BYTE;
      compare8_a      <= `RST_BYTE;
      compare8_b      <= `RST_BYTE;
      block_match_reg <= 1'b0;
      wave_out_a      <= 1'b0;
      wave_out_b      <= 1'b0;
    end else begin
      if (wr_ctrl0) begin
        clk_sel_reg <= wbyte[`CLK_SEL_MSB:`CLK_SEL_LSB];
      end
      if (wr_cmpa) begin
        compare8_a <= wbyte;
      end
      if (wr_cmpb) begin
        compare8_b <= wbyte;
      end
      // A write beats a tick landing in the same cycle
      if (wr_cnt0) begin
        counter8_value  <= wbyte;
        block_match_reg <= 1'b1;
      end else if (tick0) begin
        counter8_value  <= counter8_value + 8'h01;
        block_match_reg <= 1'b0;
      end
      if (match_a) begin
        wave_out_a <= ~wave_out_a;
      end
      if (match_b) begin
        wave_out_b <= ~wave_out_b;
      end
    end
  end

  // Timer1 counter and compare word
  always @(posedge aclk) begin
    if (!aresetn) begin
      t1_mode_reg       <= `MODE_NORMAL;
      t1_sel_reg        <= `SEL_STOP;
      counter16_value   <= `RST_WORD;
      count_up_reg      <= 1'b1;
      compare16_word    <= `RST_WORD;
      compare16_buf_reg <= `RST_WORD;
      high_latch_reg    <= `RST_BYTE;
      wave_out_16       <= 1'b0;
    end else begin
      if (wr_ctrl1) begin
        t1_mode_reg <= wbyte[`T1_MODE_MSB:`T1_MODE_LSB];
        t1_sel_reg  <= wbyte[`T1_SEL_MSB:`T1_SEL_LSB];
      end
      if (wr_high) begin
        high_latch_reg <= wbyte;
      end
      if (wr_low && dbuf_on) begin
        compare16_buf_reg <= {high_latch_reg, wbyte};
      end
      if (wr_low && !dbuf_on) begin
        compare16_word <= {high_latch_reg, wbyte};
      end else if (refresh) begin
        compare16_word <= compare16_buf_reg;
      end
      // Counter low write completes a latched 16-bit value too
      if (wr_cnt1) begin
        counter16_value <= {high_latch_reg, wbyte};
      end else if (tick1) begin
        if (!mode_updown) begin
          counter16_value <= at_top ? `RST_WORD
                                    : counter16_value + 16'h0001;
        end else if (count_up_reg) begin
          if (at_top) begin
            count_up_reg    <= 1'b0;
            counter16_value <= counter16_value - 16'h0001;
          end else begin
            counter16_value <= counter16_value + 16'h0001;
          end
        end else begin
          if (at_bot) begin
            count_up_reg    <= 1'b1;
            counter16_value <= counter16_value + 16'h0001;
          end else begin
            counter16_value <= counter16_value - 16'h0001;
          end
        end
      end
      if (match16) begin
        wave_out_16 <= ~wave_out_16;
      end
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= {`ST_WIDTH{1'b0}};
      enable_reg <= {`ST_WIDTH{1'b0}};
    end else begin
      if (wr_clear) begin
        status_reg <= (status_reg & ~wbyte[`ST_WIDTH-1:0]) | st_set;
      end else begin
        status_reg <= status_reg | st_set;
      end
      if (wr_enable) begin
        enable_reg <= wbyte[`ST_WIDTH-1:0];
      end
    end
  end

endmodule // timer_compare_core

// ==== timer_compare_core_properties.sv ====
`timescale 1ns/1ns
module timer_compare_core_properties (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire wave_out_a,
  input wire wave_out_b,
  input wire irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wr_block_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel open during response");
  rd_block_a: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open during response");
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after take");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after take");
  b_release_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after accept");
  r_release_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after accept");
  reset_quiet_a: assert property (
    $rose(aresetn) |-> !irq && !wave_out_a && !wave_out_b && !s_axi_bvalid)
    else $error("outputs not idle after reset");
  irq_sticky_a: assert property (
    $fell(irq) |-> s_axi_bvalid)
    else $error("interrupt dropped without a register write");
endmodule // timer_compare_core_properties

bind timer_compare_core timer_compare_core_properties chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .irq(irq));

// ==== tb_timer_compare_core.sv ====
`timescale 1ns/1ns
`include "timer_compare_core_map.vh"
module tb_timer_compare_core;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [7:0]  awaddr = 8'h00;
  reg  [7:0]  araddr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg  [3:0]  wstrb = 4'hf;
  reg         awvalid = 1'b0;
  reg         wvalid = 1'b0;
  reg         bready = 1'b0;
  reg         arvalid = 1'b0;
  reg         rready = 1'b0;
  reg         pin = 1'b0;
  wire        awready, wready, bvalid, arready, rvalid;
  wire        wave_a, wave_b, wave_16, irq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     error_cnt = 0;
  integer     tests_run = 0;
  integer     cyc = 0;
  integer     i, t0;
  integer     dv[0:5];
  reg  [7:0]  c, h, l;
  reg         w;
  reg  [33:0] rq[$];
  reg  [1:0]  bq[$];

  timer_compare_core uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_count_pin(pin), .wave_out_a(wave_a), .wave_out_b(wave_b),
    .wave_out_16(wave_16), .irq(irq));

  initial forever #5 aclk = ~aclk;

  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task check(input [33:0] seen, input [33:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask

  task chk1(input seen, input exp);
    check({33'h0, seen}, {33'h0, exp});
  endtask

  // Idle slave takes address and data together; the trailing edge
  // keeps two back-to-back calls from driving a signal twice at once
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      bq.push_back(er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge aclk); while (!(awready && wready));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      @(posedge aclk);
    end
  endtask

  task rd(input [7:0] a, input [33:0] e);
    begin
      rq.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
      @(posedge aclk);
    end
  endtask

  // Start and stop writes run alike, so the count window is exactly n
  task run_for(input [2:0] code, input integer n);
    begin
      t0 = cyc;
      wr(`OFS_T0_CTRL, {29'h0, code}, `RESP_OKAY);
      while (cyc < t0 + n) @(posedge aclk);
      wr(`OFS_T0_CTRL, 32'h0, `RESP_OKAY);
    end
  endtask

  // Same window for timer1; the stop write keeps the mode field
  task run1(input [31:0] ctl, input integer n);
    begin
      t0 = cyc;
      wr(`OFS_T1_CTRL, ctl, `RESP_OKAY);
      while (cyc < t0 + n) @(posedge aclk);
      wr(`OFS_T1_CTRL, ctl & 32'hf, `RESP_OKAY);
    end
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (bvalid && bready)
      check({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid && rready)
      check({rresp, rdata}, rq.pop_front());
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end

  initial begin
    dv[0] = 1; dv[1] = 1; dv[2] = 8; dv[3] = 64; dv[4] = 256; dv[5] = 1024;
    i = $urandom(14134);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`OFS_T0_CTRL, 34'h0);
    rd(`OFS_T0_COUNT, 34'h0);
    rd(`OFS_IRQ_STATUS, 34'h0);
    rd(8'h30, {`RESP_SLVERR, 32'h0});
    wr(8'h2c, 32'h1, `RESP_SLVERR);
    c = $urandom;
    wr(`OFS_T0_COUNT, {24'h0, c}, `RESP_OKAY);
    rd(`OFS_T0_COUNT, {26'h0, c});
    wstrb <= 4'h0;
    wr(`OFS_T0_COUNT, {24'h0, ~c}, `RESP_OKAY);
    wstrb <= 4'hf;
    rd(`OFS_T0_COUNT, {26'h0, c});
    $display("test register access done");
    for (i = 0; i < 6; i = i + 1) begin
      wr(`OFS_T0_COUNT, 32'h0, `RESP_OKAY);
      run_for(i, 8 * dv[i]);
      rd(`OFS_T0_COUNT, (i == 0) ? 34'h0 : 34'h8);
    end
    $display("test prescaler done");
    for (i = 6; i < 8; i = i + 1) begin
      wr(`OFS_T0_COUNT, 32'h0, `RESP_OKAY);
      wr(`OFS_T0_CTRL, i, `RESP_OKAY);
      repeat (i - 3) begin
        pin <= 1'b1;
        repeat (4) @(posedge aclk);
        pin <= 1'b0;
        repeat (4) @(posedge aclk);
      end
      repeat (4) @(posedge aclk);
      wr(`OFS_T0_CTRL, 32'h0, `RESP_OKAY);
      rd(`OFS_T0_COUNT, i - 3);
    end
    $display("test external pin done");
    c = $urandom_range(200, 16);
    wr(`OFS_T0_CMP_A, {24'h0, c}, `RESP_OKAY);
    wr(`OFS_T0_CMP_B, 32'hff, `RESP_OKAY);
    wr(`OFS_T0_COUNT, 32'h0, `RESP_OKAY);
    wr(`OFS_IRQ_CLEAR, 32'hf, `RESP_OKAY);
    wr(`OFS_IRQ_ENABLE, 32'h1, `RESP_OKAY);
    w = wave_a;
    wr(`OFS_T0_CTRL, `SEL_DIV1, `RESP_OKAY);
    t0 = cyc;
    while (!irq && cyc < t0 + 300) @(posedge aclk);
    wr(`OFS_T0_CTRL, 32'h0, `RESP_OKAY);
    chk1(irq, 1'b1);
    chk1(wave_a, ~w);
    rd(`OFS_IRQ_STATUS, 34'h1);
    wr(`OFS_IRQ_ENABLE, 32'h0, `RESP_OKAY);
    chk1(irq, 1'b0);
    wr(`OFS_IRQ_ENABLE, 32'h1, `RESP_OKAY);
    chk1(irq, 1'b1);
    wr(`OFS_IRQ_CLEAR, 32'h1, `RESP_OKAY);
    chk1(irq, 1'b0);
    $display("test compare interrupt done");
    w = wave_a;
    wr(`OFS_T0_COUNT, {24'h0, c}, `RESP_OKAY);
    run_for(`SEL_DIV1, 8);
    rd(`OFS_T0_COUNT, c + 8);
    rd(`OFS_IRQ_STATUS, 34'h0);
    chk1(wave_a, w);
    $display("test blocked match done");
    w = wave_b;
    wr(`OFS_T0_CMP_B, 32'hfc, `RESP_OKAY);
    wr(`OFS_T0_COUNT, 32'hf8, `RESP_OKAY);
    run_for(`SEL_DIV1, 8);
    rd(`OFS_T0_COUNT, 34'h0);
    rd(`OFS_IRQ_STATUS, 34'h6);
    chk1(wave_b, ~w);
    wr(`OFS_IRQ_CLEAR, 32'hf, `RESP_OKAY);
    $display("test match b and wrap done");
    for (i = 0; i < 2; i = i + 1) begin
      wr(`OFS_T1_CTRL, i, `RESP_OKAY);
      h = $urandom;
      l = $urandom;
      wr(`OFS_C16_HIGH, {24'h0, h}, `RESP_OKAY);
      wr(`OFS_C16_LOW, {24'h0, l}, `RESP_OKAY);
      wr(`OFS_C16_HIGH, {24'h0, ~h}, `RESP_OKAY);
      rd(`OFS_C16_LOW, {26'h0, l});
      rd(`OFS_C16_HIGH, {26'h0, h});
      wr(`OFS_C16_LOW, {24'h0, ~l}, `RESP_OKAY);
      rd(`OFS_C16_LOW, {26'h0, ~l});
      rd(`OFS_C16_HIGH, {26'h0, ~h});
    end
    $display("test word compare done");
    wr(`OFS_T1_CTRL, `MODE_NORMAL, `RESP_OKAY);
    wr(`OFS_C16_HIGH, 32'h0, `RESP_OKAY);
    wr(`OFS_C16_LOW, 32'h5, `RESP_OKAY);
    wr(`OFS_T1_COUNT, 32'h0, `RESP_OKAY);
    w = wave_16;
    run1(32'h10, 10);
    chk1(wave_16, ~w);
    rd(`OFS_T1_COUNT, 34'ha);
    // Active word 0x0200 is out of reach of the 8-bit slope
    wr(`OFS_C16_HIGH, 32'h2, `RESP_OKAY);
    wr(`OFS_C16_LOW, 32'h0, `RESP_OKAY);
    wr(`OFS_T1_CTRL, 32'h1, `RESP_OKAY);
    wr(`OFS_C16_HIGH, 32'h0, `RESP_OKAY);
    wr(`OFS_C16_LOW, 32'h10, `RESP_OKAY);
    wr(`OFS_T1_COUNT, 32'h0, `RESP_OKAY);
    // Only the down slope match after TOP may toggle in 510 ticks
    w = wave_16;
    run1(32'h11, 510);
    chk1(wave_16, ~w);
    rd(`OFS_C16_LOW, 34'h10);
    rd(`OFS_C16_HIGH, 34'h0);
    rd(`OFS_IRQ_STATUS, 34'h8);
    $display("test double buffer done");
    report_and_stop;
  end
endmodule // tb_timer_compare_core
